// >>> universal_serial_shift_unit_test.sv
// Self-checking bench for the serial shift unit core.
// Assumes a mode 0 master peer; software requests are one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module universal_serial_shift_unit_test
  import uss_pkg::*;
;
  logic sys_clk, rst, timer_match, dir_sck, dir_data, ovf_flag, d, start_flag;
  logic peer_sck, peer_mosi;
  wire logic sck_wire;
  uss_req_s req;
  uss_stat_s stat;
  uss_ctrl_s ctrl;
  uss_pins_s pins;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] v, w, rxp;

  assign sck_wire = pins.sck_oe_n ? peer_sck : pins.sck_out;

  uss_core dut_u (.sys_clk(sys_clk), .rst(rst), .serial_clk_link(sck_wire),
    .serial_clock_pin_in(sck_wire), .serial_data_in_pin(peer_mosi),
    .timer_match(timer_match), .port_dir_sck(dir_sck),
    .port_dir_data(dir_data), .req(req), .stat(stat), .ctrl(ctrl),
    .counter_overflow_flag(ovf_flag), .start_condition_flag(start_flag),
    .pins(pins));
  uss_spi_peer peer_u (.sck(peer_sck), .mosi(peer_mosi),
    .miso(pins.do_out), .miso_oe_n(pins.do_oe_n));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask : chk

  task automatic step(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic pulse(input uss_req_s r);
    req = r;
    step();
    req = '0;
    // An idle edge between requests keeps every strobe a clean pulse
    step();
  endtask : pulse

  function automatic logic [7:0] shl(input logic [7:0] x, input logic b);
    return {x[6:0], b};
  endfunction : shl

  function automatic uss_req_s sw_req(input int k, input logic [7:0] x);
    uss_req_s r;
    r = '0;
    r.sr_wdata = x;
    r.cnt_wdata = x[3:0];
    r.port_sck_val = x[0];
    r.sr_wr = (k == 0);
    r.cnt_wr = (k == 1);
    r.clr_ovf = (k == 2);
    r.port_sck_wr = (k == 3);
    return r;
  endfunction : sw_req

  function automatic uss_req_s wr_ctrl(input uss_wm_e wm, input logic ext,
      input logic es, input logic sw, input logic tc);
    uss_req_s r;
    r = '0;
    r.ctrl_wr = 1'b1;
    r.ctrl = '{wm, ext, es, sw};
    r.clock_toggle_strobe = tc;
    return r;
  endfunction : wr_ctrl

  initial begin
    uss_req_s r;
    void'($urandom(32'h7A3F));
    rst = 1'b1;
    req = '0;
    timer_match = 1'b0;
    dir_sck = 1'b0;
    dir_data = 1'b1;
    step(5);
    rst = 1'b0;
    step(3);
    chk(stat.sr, SR_RST, "sr reset"); // reset
    chk(8'(ovf_flag), 8'h00, "flag reset"); // reset
    pulse(wr_ctrl(USS_WM_THREE, 1'b0, 1'b1, 1'b0, 1'b0));
    for (int i = 0; i < 2; i++) begin
      v = {i[0], 7'($urandom)};
      pulse(sw_req(0, v));
      chk(stat.sr, v, "sr write"); // write
      chk(8'(pins.do_out), 8'(v[7]), "msb out"); // latch
      chk(8'(pins.do_oe_n), 8'h00, "out enable"); // pin
    end
    pulse(sw_req(1, 8'h00));
    for (int i = 0; i < 8; i++) begin
      d = 1'($urandom);
      peer_u.mosi = d;
      step(5);
      pulse(wr_ctrl(USS_WM_THREE, 1'b0, 1'b0, 1'b0, 1'b0));
      chk(stat.sr, v, "no strobe"); // pair
      pulse(wr_ctrl(USS_WM_THREE, 1'b0, 1'b0, 1'b1, 1'b0));
      v = shl(v, d);
      chk(stat.sr, v, "soft shift"); // input
      chk(8'(stat.cnt), 8'(i + 1), "soft count"); // count
    end
    w = 8'($urandom);
    r = wr_ctrl(USS_WM_THREE, 1'b0, 1'b0, 1'b1, 1'b0);
    r.sr_wr = 1'b1;
    r.sr_wdata = w;
    pulse(r);
    chk(stat.sr, w, "write vs shift"); // write
    pulse(wr_ctrl(USS_WM_THREE, 1'b0, 1'b1, 1'b0, 1'b0));
    pulse(sw_req(1, 8'(CNT_TOP)));
    timer_match = 1'b1;
    step();
    timer_match = 1'b0;
    w = shl(w, d);
    chk(stat.sr, w, "timer shift"); // source
    chk(8'(stat.cnt), 8'(CNT_RST), "wrap count"); // wrap
    chk(stat.cp, w, "copy on wrap"); // copy
    step(3);
    chk(8'(ovf_flag), 8'h01, "flag held"); // held
    pulse(sw_req(1, 8'h05));
    pulse(sw_req(2, 8'h00));
    chk(8'(ovf_flag), 8'h00, "flag clear"); // flag
    chk(8'(stat.cnt), 8'h00, "clear count"); // count
    pulse(wr_ctrl(USS_WM_THREE, 1'b1, 1'b0, 1'b0, 1'b0));
    repeat (3) begin
      v = 8'($urandom);
      w = 8'($urandom);
      pulse(sw_req(2, 8'h00));
      pulse(sw_req(0, v));
      peer_u.xfer(w, rxp);
      step(12);
      chk(rxp, v, "peer rx"); // exchange
      chk(stat.sr, w, "unit rx"); // edges
      chk(stat.cp, w, "copy buf"); // copy
      chk(8'(ovf_flag), 8'h01, "ovf set"); // overflow
      chk(8'(stat.cnt), 8'h00, "edge count"); // edges
    end
    dir_sck = 1'b1;
    pulse(sw_req(3, 8'h01));
    chk(8'(pins.sck_out), 8'h01, "port clock"); // port
    step(6);
    pulse(sw_req(1, 8'h00));
    for (int i = 1; i <= 4; i++) begin
      pulse(wr_ctrl(USS_WM_THREE, 1'b1, 1'b0, 1'b1, 1'b1));
      chk(8'(pins.sck_out), 8'(!i[0]), "toggle"); // toggle
      chk(8'(stat.cnt), 8'(i), "strobe count"); // count
      step(6);
    end
    peer_u.sck = 1'b1;
    peer_u.mosi = 1'b1;
    step(6);
    pulse(wr_ctrl(USS_WM_TWO, 1'b1, 1'b0, 1'b0, 1'b0));
    chk(8'(ctrl), 8'h14, "ctrl stored"); // select
    chk(8'(start_flag), 8'h00, "no start"); // idle
    peer_u.mosi = 1'b0;
    step(6);
    chk(8'(start_flag), 8'h01, "start flag"); // start
    chk(8'(pins.sck_oe_n), 8'h01, "clock free"); // high
    peer_u.sck = 1'b0;
    step(6);
    chk(8'(pins.sck_oe_n), 8'h00, "clock held"); // hold
    r = '0;
    r.clr_start = 1'b1;
    pulse(r);
    chk(8'(start_flag), 8'h00, "start clear"); // clear
    chk(8'(pins.sck_oe_n), 8'h01, "clock freed"); // release
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(3);
    chk(8'(ovf_flag), 8'h00, "flag reset again"); // reset
    chk(stat.sr, SR_RST, "sr reset again"); // reset
    report_and_stop();
  end
endmodule : universal_serial_shift_unit_test
`default_nettype wire

// >>> uss_core.sv
// Serial shift unit: shift register, copy buffer, edge counter, latch.
// Assumes software strobes are one sys_clk pulses; pins are async.
`timescale 1ns/100ps
`default_nettype none
module uss_core
  import uss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic serial_clk_link,
  input wire logic serial_clock_pin_in,
  input wire logic serial_data_in_pin,
  input wire logic timer_match,
  input wire logic port_dir_sck,
  input wire logic port_dir_data,
  input wire uss_req_s req,
  output uss_stat_s stat,
  output uss_ctrl_s ctrl,
  output logic counter_overflow_flag,
  output logic start_condition_flag,
  output uss_pins_s pins
);

  typedef struct packed {
    uss_stat_s st;
    uss_ctrl_s ctrl;
    uss_pins_s pins;
    logic latch;
    logic port_sck;
    logic sck_d;
    logic sda_d;
  } uss_state_s;

  localparam uss_state_s ST_RST = '{
    '{SR_RST, SR_RST, CNT_RST, 1'b0, 1'b0, 1'b0},
    CTRL_RST, PINS_RST, 1'b0, 1'b0, 1'b0, 1'b1};

  uss_state_s s_r;
  uss_state_s s_nxt;

  // Link side: data-in caught on each serial clock edge
  logic rise_bit_r;
  logic fall_bit_r;

  always_ff @(posedge serial_clk_link or posedge rst) begin
    if (rst) begin
      rise_bit_r <= 1'b0;
    end else begin
      rise_bit_r <= serial_data_in_pin;
    end
  end

  always_ff @(negedge serial_clk_link or posedge rst) begin
    if (rst) begin
      fall_bit_r <= 1'b0;
    end else begin
      fall_bit_r <= serial_data_in_pin;
    end
  end

  logic [SY_W-1:0] sy_d;
  logic [SY_W-1:0] sy_q;

  assign sy_d = {fall_bit_r, rise_bit_r, serial_data_in_pin,
                 serial_clock_pin_in};

  // pin and link bits brought into sys_clk
  uss_sync #(.W(SY_W)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d(sy_d),
    .q(sy_q)
  );

  logic ssck;
  logic sdi;
  uss_ctrl_s cur;
  logic two_wire;
  logic sck_rise;
  logic sck_fall;
  logic ext_shift;
  logic int_ev;
  logic shift_ev;
  logic shift_bit;
  logic cnt_ev;
  logic wrap;
  logic start_det;
  logic latch_open;
  logic [DATA_W-1:0] sr_shifted;

  assign ssck = sy_q[SY_SCK];
  assign sdi = sy_q[SY_DI];
  // A control write takes effect with the strobes it carries
  assign cur = req.ctrl_wr ? req.ctrl : s_r.ctrl;
  assign two_wire = cur.wm[1];
  assign sck_rise = ssck & ~s_r.sck_d;
  assign sck_fall = ~ssck & s_r.sck_d;

  // shift on the edge opposite the sampling edge
  assign ext_shift = cur.edge_sel ? sck_rise : sck_fall;
  // internal sources: software strobe or timer match
  // one event per strobe write, so at best half rate
  assign int_ev = ~cur.ext_sel & (cur.edge_sel ? timer_match
                  : (req.ctrl_wr & req.ctrl.sw_clk));
  // internal sources drive register and counter alike; external mode counts both edges (toggle strobes when sw_clk is set) but shifts on one
  assign shift_ev = cur.ext_sel ? ext_shift : int_ev;
  // Bit was caught on the sampling edge; stable half a period later
  assign shift_bit = cur.ext_sel
                     ? (cur.edge_sel ? sy_q[SY_FALL] : sy_q[SY_RISE])
                     : sdi;
  // MSB leaves first, the sampled input bit enters at bit 0
  assign sr_shifted = {s_r.st.sr[DATA_W-2:0], shift_bit};

  // both edges count; toggle strobe counts instead
  assign cnt_ev = cur.ext_sel
                  ? (cur.sw_clk ? (req.ctrl_wr & req.clock_toggle_strobe)
                     : (sck_rise | sck_fall))
                  : int_ev;
  // wrap from the top value marks completion
  assign wrap = cnt_ev & (s_r.st.cnt == CNT_TOP) & ~req.cnt_wr;

  // data falls while clock is high
  assign start_det = two_wire & s_r.sda_d & ~sdi & ssck;

  // latch open in first half of an external cycle
  assign latch_open = ~cur.ext_sel | (ssck == cur.edge_sel);

  always_comb begin
    s_nxt = s_r;
    s_nxt.sck_d = ssck;
    s_nxt.sda_d = sdi;
    if (req.ctrl_wr) begin
      s_nxt.ctrl = req.ctrl;
    end

    // port bit write or toggle strobe moves the clock pin
    if (req.port_sck_wr) begin
      s_nxt.port_sck = req.port_sck_val;
    end else if (req.ctrl_wr && req.clock_toggle_strobe) begin
      s_nxt.port_sck = ~s_r.port_sck;
    end

    if (shift_ev) begin
      s_nxt.st.sr = sr_shifted;
    end
    if (req.sr_wr) begin
      s_nxt.st.sr = req.sr_wdata;
    end

    // counter advances, software may load it
    if (cnt_ev) begin
      s_nxt.st.cnt = s_r.st.cnt + 4'h1;
    end
    if (req.cnt_wr) begin
      s_nxt.st.cnt = req.cnt_wdata;
    end

    // flag clear zeroes counter; a same-cycle wrap keeps flag
    if (req.clr_ovf) begin
      s_nxt.st.cnt = CNT_RST;
      s_nxt.st.ovf = 1'b0;
    end
    if (wrap) begin
      s_nxt.st.ovf = 1'b1;
    end
    // completed byte copied to the buffer
    if (wrap) begin
      s_nxt.st.cp = s_nxt.st.sr;
    end

    if (req.clr_start) begin
      s_nxt.st.start = 1'b0;
    end
    if (start_det) begin
      s_nxt.st.start = 1'b1;
    end

    // wait states after start, or after overflow in hold mode
    s_nxt.st.hold = two_wire
                    & ((s_nxt.st.start & (s_r.st.hold | ~ssck))
                       | ((cur.wm == USS_WM_TWO_OVF) & s_nxt.st.ovf));

    if (latch_open) begin
      s_nxt.latch = s_nxt.st.sr[DATA_W-1];
    end

    case (cur.wm)
      USS_WM_NONE: begin
        s_nxt.pins = PINS_RST;
        s_nxt.pins.sck_out = s_nxt.port_sck;
        s_nxt.pins.sck_oe_n = ~port_dir_sck;
      end
      // plain push-pull clock and data, no select
      USS_WM_THREE: begin
        s_nxt.pins.do_out = s_nxt.latch;
        s_nxt.pins.do_oe_n = ~port_dir_data;
        s_nxt.pins.sda_out = 1'b0;
        s_nxt.pins.sda_oe_n = 1'b1;
        s_nxt.pins.sck_out = s_nxt.port_sck;
        s_nxt.pins.sck_oe_n = ~port_dir_sck;
      end
      USS_WM_TWO, USS_WM_TWO_OVF: begin
        // Open drain: only ever pulls low
        s_nxt.pins.do_out = 1'b0;
        s_nxt.pins.do_oe_n = 1'b1;
        s_nxt.pins.sda_out = 1'b0;
        s_nxt.pins.sda_oe_n = ~(port_dir_data & ~s_nxt.latch);
        s_nxt.pins.sck_out = 1'b0;
        s_nxt.pins.sck_oe_n = ~((port_dir_sck & ~s_nxt.port_sck)
                                | s_nxt.st.hold);
      end
      default: begin
        s_nxt.pins = PINS_RST;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign stat = s_r.st;
  assign ctrl = s_r.ctrl;
  assign pins = s_r.pins;
  // level request usable as an idle wake source
  assign counter_overflow_flag = s_r.st.ovf;
  assign start_condition_flag = s_r.st.start;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_wrap;
    wrap ##1 1'b1;
  endsequence

  sequence s_toggle;
    req.ctrl_wr && req.clock_toggle_strobe && !req.port_sck_wr;
  endsequence

  wr_beats_shift_a: assert property (
    req.sr_wr |=> stat.sr == $past(req.sr_wdata))
    else $error("shift register lost a software write");

  // shift moves bits up by one
  shift_msb_a: assert property (
    shift_ev && !req.sr_wr |=> stat.sr[7:1] == $past(stat.sr[6:0]))
    else $error("shift did not move bits up");

  // wrap sets flag and zeroes count
  ovf_wrap_a: assert property (
    wrap && !req.clr_ovf |=> counter_overflow_flag && stat.cnt == 4'h0)
    else $error("wrap did not set overflow flag");

  ovf_sticky_a: assert property (
    counter_overflow_flag && !req.clr_ovf |=> counter_overflow_flag)
    else $error("overflow flag dropped without clear");

  clr_resets_cnt_a: assert property (
    req.clr_ovf && !wrap |=> !counter_overflow_flag && stat.cnt == 4'h0)
    else $error("flag clear did not reset counter");

  copy_on_wrap_a: assert property (
    s_wrap |-> stat.cp == stat.sr)
    else $error("buffer not loaded on completion");

  // toggle strobe flips clock pin state
  toggle_pin_a: assert property (
    s_toggle |=> s_r.port_sck != $past(s_r.port_sck))
    else $error("toggle strobe did not flip clock");

  // each count event (edge, toggle strobe or internal event) advances the count
  edge_count_a: assert property (
    cnt_ev && !req.cnt_wr && !req.clr_ovf
    |=> stat.cnt == $past(stat.cnt) + 4'h1)
    else $error("counter missed a clock event");

  three_wire_pin_a: assert property (
    s_r.ctrl.wm == USS_WM_THREE && !req.ctrl_wr
    ##1 s_r.ctrl.wm == USS_WM_THREE |-> pins.do_out == s_r.latch)
    else $error("data pin not driven from latch");

  // start seen on the bus raises flag
  start_flag_a: assert property (
    start_det |=> start_condition_flag)
    else $error("start condition not flagged");

  // closed latch keeps the output bit
  latch_closed_a: assert property (
    !latch_open |=> $stable(s_r.latch))
    else $error("output latch moved while closed");

  // counter moves only on a clock event, write or flag clear
  cnt_idle_a: assert property (
    !cnt_ev && !req.cnt_wr && !req.clr_ovf |=> $stable(stat.cnt))
    else $error("counter moved without a clock event");

  // wait state pulls the clock line low
  hold_low_a: assert property (
    stat.hold |-> !pins.sck_oe_n)
    else $error("clock not held low in wait state");

  // three-wire data output follows its direction bit
  data_enable_a: assert property (
    s_r.ctrl.wm == USS_WM_THREE |-> pins.do_oe_n == !$past(port_dir_data))
    else $error("data output enable wrong in three-wire mode");

endmodule : uss_core
`default_nettype wire

// >>> uss_pkg.sv
// Shared constants and carrier types for the serial shift unit.
// Assumes a single system clock; pins are sampled by the core.
package uss_pkg;

  localparam int DATA_W = 8;
  localparam int CNT_W = 4;

  localparam logic [CNT_W-1:0] CNT_TOP = 4'hF;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [DATA_W-1:0] SR_RST = 8'h00;

  // Stages of the pin synchroniser
  localparam int SYNC_STAGES = 3;

  // Bit positions inside the synchronised pin vector
  localparam int SY_SCK = 0;
  localparam int SY_DI = 1;
  localparam int SY_RISE = 2;
  localparam int SY_FALL = 3;
  localparam int SY_W = 4;

  typedef enum logic [1:0] {
    USS_WM_NONE = 2'b00,
    USS_WM_THREE = 2'b01,
    USS_WM_TWO = 2'b10,
    USS_WM_TWO_OVF = 2'b11
  } uss_wm_e;

  typedef struct packed {
    uss_wm_e wm;
    logic ext_sel;
    logic edge_sel;
    logic sw_clk;
  } uss_ctrl_s;

  localparam uss_ctrl_s CTRL_RST = '{USS_WM_NONE, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic sr_wr;
    logic [DATA_W-1:0] sr_wdata;
    logic cnt_wr;
    logic [CNT_W-1:0] cnt_wdata;
    logic clr_ovf;
    logic clr_start;
    logic ctrl_wr;
    uss_ctrl_s ctrl;
    logic clock_toggle_strobe;
    logic port_sck_wr;
    logic port_sck_val;
  } uss_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] sr;
    logic [DATA_W-1:0] cp;
    logic [CNT_W-1:0] cnt;
    logic ovf;
    logic start;
    logic hold;
  } uss_stat_s;

  typedef struct packed {
    logic do_out;
    logic do_oe_n;
    logic sda_out;
    logic sda_oe_n;
    logic sck_out;
    logic sck_oe_n;
  } uss_pins_s;

  localparam uss_pins_s PINS_RST = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

endpackage : uss_pkg

// >>> uss_spi_peer.sv
// Mode 0 serial master standing on the far side of the three-wire link.
// Assumes the unit waits as slave with its data output enabled.
`timescale 1ns/100ps
`default_nettype none
module uss_spi_peer
  import uss_pkg::*;
(
  output logic sck,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  logic last_r;
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    last_r = 1'b0;
  end
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    #3.3;
    mosi = sh[7];
    #80;
    repeat (8) begin
      sck = 1'b1;
      // Released line shows no stale value
      last_r = miso_oe_n ? ~last_r : miso;
      sh = {sh[6:0], last_r};
      #80;
      sck = 1'b0;
      mosi = sh[7];
      #80;
    end
    rx = sh;
    mosi = ~mosi;
  endtask : xfer
endmodule : uss_spi_peer
`default_nettype wire

// >>> uss_sync.sv
// Three-stage synchroniser with agreement filter, one lane per bit.
// Assumes inputs may change at any time relative to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module uss_sync
  import uss_pkg::*;
#(
  parameter int W = SY_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_nxt;

  // A lane moves only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q[i];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q <= q_nxt;
    end
  end

endmodule : uss_sync
`default_nettype wire
